// file: test/gamma_select_display_onoff_cmd_test.sv
/*
  Self-checking bench for the gamma-select and display on/off command decoder.
  Assumes the host model drives the bus pins and the bench drives reset and frame start.
*/
`timescale 1ns/1ps
module gamma_select_display_onoff_cmd_test import gsd_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic frame_start = 1'b0;
  logic sel, wr_n, rd_n;
  logic [7:0] data, gamma, lfsr, exp_g, v;
  logic [3:0] onehot;
  logic disp_on, disp_req, exp_req;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] codes [4] = '{GSD_GAMMA_CURVE_FOUR, GSD_GAMMA_CURVE_THREE,
    GSD_GAMMA_CURVE_TWO, GSD_GAMMA_CURVE_ONE};

  initial begin
    forever #2 clk = ~clk;
  end

  gsd_host_model gsd_host_model_inst (.i_clk_sys(clk), .o_cmd_data_select(sel),
    .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n), .o_data(data));
  gsd_cmd_decoder gsd_cmd_decoder_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_cmd_data_select(sel), .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n),
    .i_data(data), .i_frame_start(frame_start), .o_gamma_curve_select(gamma),
    .o_curve_onehot(onehot), .o_display_on(disp_on), .o_display_on_req(disp_req));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Only the four one-hot codes move the selection; anything else keeps it.
  function automatic logic [7:0] next_gamma(input logic [7:0] cur, input logic [7:0] p);
    return (p == 8'h01 || p == 8'h02 || p == 8'h04 || p == 8'h08) ? p : cur;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic put(input logic s, input logic [7:0] b, input logic r);
    gsd_host_model_inst.send(s, b, r);
    repeat (4) @(posedge clk);
  endtask

  task automatic check_all();
    check(gamma, exp_g);
    check({4'h0, onehot}, {4'h0, exp_g[3:0]});
    check({7'h00, disp_req}, {7'h00, exp_req});
  endtask

  task automatic frame();
    @(posedge clk);
    frame_start <= 1'b1;
    repeat (2) @(posedge clk);
    frame_start <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic reset_and_check();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    exp_g = GSD_GAMMA_RESET;
    exp_req = 1'b0;
    check_all();
    check({7'h00, disp_on}, 8'h00);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    lfsr = 8'h32;
    reset_and_check();
    for (int i = 0; i < 4; i++) begin
      put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
      put(1'b1, codes[i], 1'b1);
      exp_g = codes[i];
      check_all();
    end
    put(1'b1, GSD_GAMMA_CURVE_THREE, 1'b1);
    check_all();
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h18 : (i % 3 == 0) ? 8'h01 << lfsr[1:0] : lfsr;
      frame_start <= lfsr[7];
      put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
      put(1'b1, v, 1'b1);
      exp_g = next_gamma(exp_g, v);
      check_all();
    end
    frame_start <= 1'b0;
    put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
    put(1'b1, (exp_g == 8'h02) ? 8'h04 : 8'h02, 1'b0);
    check_all();
    put(1'b0, 8'h00, 1'b1);
    put(1'b1, (exp_g == 8'h02) ? 8'h04 : 8'h02, 1'b1);
    check_all();
    v = (exp_g == GSD_GAMMA_CURVE_FOUR) ? GSD_GAMMA_CURVE_ONE : GSD_GAMMA_CURVE_FOUR;
    put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
    put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
    put(1'b1, v, 1'b1);
    exp_g = v;
    check_all();
    reset_and_check();
    put(1'b0, GSD_CMD_DISPLAY_ON, 1'b1);
    exp_req = 1'b1;
    check_all();
    check({7'h00, disp_on}, 8'h00);
    frame();
    check({7'h00, disp_on}, 8'h01);
    put(1'b0, GSD_CMD_DISPLAY_ON, 1'b1);
    put(1'b0, GSD_CMD_GAMMA_SELECT, 1'b1);
    put(1'b1, GSD_GAMMA_CURVE_TWO, 1'b1);
    exp_g = GSD_GAMMA_CURVE_TWO;
    frame();
    check_all();
    check({7'h00, disp_on}, 8'h01);
    put(1'b0, GSD_CMD_DISPLAY_OFF, 1'b1);
    exp_req = 1'b0;
    check({7'h00, disp_on}, 8'h01);
    frame();
    check({7'h00, disp_on}, 8'h00);
    check_all();
    put(1'b0, GSD_CMD_DISPLAY_OFF, 1'b1);
    frame();
    check_all();
    check({7'h00, disp_on}, 8'h00);
    put(1'b0, GSD_CMD_DISPLAY_ON, 1'b1);
    frame();
    reset_and_check();
    complete_run();
  end
endmodule // gamma_select_display_onoff_cmd_test

// file: test/gsd_host_model.sv
/*
  Behavioural host controller that writes bytes over the 8080-style command bus.
  Assumes send is called right after a rising edge of i_clk_sys, from one process only.
*/
`timescale 1ns/1ps
module gsd_host_model (
  input wire logic i_clk_sys,
  output logic o_cmd_data_select,
  output logic o_write_strobe_n,
  output logic o_read_strobe_n,
  output logic [7:0] o_data
);
  initial begin
    o_cmd_data_select = 1'b0;
    o_write_strobe_n = 1'b1;
    o_read_strobe_n = 1'b1;
    o_data = 8'h00;
  end

  // Select and byte settle a clock ahead of the low phase and outlast the rise.
  task automatic send(input logic sel, input logic [7:0] val, input logic rd_n);
    @(posedge i_clk_sys);
    o_cmd_data_select <= sel;
    o_data <= val;
    o_read_strobe_n <= rd_n;
    @(posedge i_clk_sys);
    o_write_strobe_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_write_strobe_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    // The released bus has no pull, so show a wrong byte rather than a held one.
    o_data <= ~val;
    o_read_strobe_n <= 1'b1;
  endtask
endmodule // gsd_host_model

// file: verilog/gsd_byte_capture.sv
/*
  Captures one host byte on each rising edge of the synchronised write strobe.
  Assumes synchronised inputs; byte and select are stable around the strobe edge.
*/
`timescale 1ns/1ps
module gsd_byte_capture
  import gsd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire gsd_byte_t i_byte,
  output gsd_byte_t o_byte,
  output logic o_valid
);
  logic strobe_prev;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= i_write_strobe_n;
    end
  end

  // A write counts only while the read strobe is idle high.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_byte <= '0;
    end else begin
      o_valid <= !strobe_prev && i_write_strobe_n && i_read_strobe_n;
      if (!strobe_prev && i_write_strobe_n) begin
        o_byte <= i_byte;
      end
    end
  end
endmodule // gsd_byte_capture

// file: verilog/gsd_cmd_decoder.sv
/*
  Command interpreter for gamma curve selection and display on/off.
  Assumes host pins are asynchronous, and the panel path honours o_display_on each frame.
*/
`timescale 1ns/1ps
module gsd_cmd_decoder
  import gsd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_cmd_data_select,
  input wire logic i_write_strobe_n,
  input wire logic i_read_strobe_n,
  input wire logic [7:0] i_data,
  input wire logic i_frame_start,
  output logic [7:0] o_gamma_curve_select,
  output logic [3:0] o_curve_onehot,
  output logic o_display_on,
  output logic o_display_on_req
);
  typedef enum logic [1:0] {
    GSD_ST_IDLE = 2'b01,
    GSD_ST_GAMMA_PARAM = 2'b10
  } gsd_state_t;

  gsd_state_t state;
  gsd_state_t next_state;
  gsd_byte_t pin_byte;
  gsd_byte_t sync_byte;
  gsd_byte_t cap_byte;
  logic sync_write_n;
  logic sync_read_n;
  logic cap_valid;
  logic frame_start_sync;
  logic is_cmd;
  logic is_param;
  logic gamma_valid;
  logic [3:0] curve_bits;

  assign pin_byte.cmd_data_select = i_cmd_data_select;
  assign pin_byte.data = i_data;

  gsd_sync #(
    .WIDTH(12),
    .RESET_VALUE(12'hC00)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async({i_write_strobe_n, i_read_strobe_n, i_frame_start, pin_byte}),
    .o_sync({sync_write_n, sync_read_n, frame_start_sync, sync_byte})
  );

  gsd_byte_capture u_capture (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_write_strobe_n(sync_write_n),
    .i_read_strobe_n(sync_read_n),
    .i_byte(sync_byte),
    .o_byte(cap_byte),
    .o_valid(cap_valid)
  );

  assign is_cmd = cap_valid && !cap_byte.cmd_data_select;
  assign is_param = cap_valid && cap_byte.cmd_data_select;

  // One-hot decode of the low nibble; upper nibble must be clear.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_curve
      assign curve_bits[g] = (cap_byte.data == (8'h01 << g));
    end
  endgenerate
  assign gamma_valid = |curve_bits;

  // No mode gating exists: commands are decoded in every power state.
  always_comb begin
    next_state = state;
    case (state)
      GSD_ST_IDLE: begin
        if (is_cmd && cap_byte.data == GSD_CMD_GAMMA_SELECT) begin
          next_state = GSD_ST_GAMMA_PARAM;
        end
      end
      GSD_ST_GAMMA_PARAM: begin
        // Any command but gamma select aborts a pending parameter; one parameter ends it.
        if (is_param) begin
          next_state = GSD_ST_IDLE;
        end else if (is_cmd && cap_byte.data != GSD_CMD_GAMMA_SELECT) begin
          next_state = GSD_ST_IDLE;
        end
      end
      default: next_state = GSD_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state <= GSD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_gamma_curve_select <= GSD_GAMMA_RESET;
      o_curve_onehot <= GSD_GAMMA_RESET[3:0];
    end else if (state == GSD_ST_GAMMA_PARAM && is_param && gamma_valid) begin
      o_gamma_curve_select <= cap_byte.data;
      o_curve_onehot <= curve_bits;
    end
  end

  // The request changes on on/off commands; besides it they only abort a pending gamma parameter.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_display_on_req <= GSD_DISPLAY_ON_RESET;
    end else if (is_cmd && cap_byte.data == GSD_CMD_DISPLAY_OFF) begin
      o_display_on_req <= 1'b0;
    end else if (is_cmd && cap_byte.data == GSD_CMD_DISPLAY_ON) begin
      o_display_on_req <= 1'b1;
    end
  end

  // Switching only at a frame boundary avoids a half-blank torn frame.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_display_on <= GSD_DISPLAY_ON_RESET;
    end else if (frame_start_sync) begin
      o_display_on <= o_display_on_req;
    end
  end

  property p_gamma_update;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == GSD_ST_GAMMA_PARAM && is_param && gamma_valid)
      |=> (o_gamma_curve_select == $past(cap_byte.data));
  endproperty
  AST_GAMMA_UPDATE: assert property (p_gamma_update)
    else $error("Gamma selection did not take the valid parameter.");

  AST_GAMMA_INVALID_KEEP: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (is_param && !gamma_valid) |=> $stable(o_gamma_curve_select))
    else $error("Invalid gamma parameter changed the curve.");

  AST_GAMMA_ONEHOT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $onehot(o_curve_onehot) && o_gamma_curve_select[7:4] == 4'h0)
    else $error("Gamma selection is not one-hot.");

  AST_GAMMA_NEEDS_CMD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (state == GSD_ST_IDLE && is_param) |=> $stable(o_gamma_curve_select))
    else $error("Parameter without gamma command changed the curve.");

  AST_GAMMA_RESET: assert property (
    @(posedge i_clk_sys) !i_rst_n |=> o_gamma_curve_select == GSD_GAMMA_RESET)
    else $error("Gamma selection not reset to curve one.");

  sequence s_off_cmd;
    is_cmd && cap_byte.data == GSD_CMD_DISPLAY_OFF;
  endsequence
  sequence s_on_cmd;
    is_cmd && cap_byte.data == GSD_CMD_DISPLAY_ON;
  endsequence

  AST_OFF_REQ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) s_off_cmd |=> !o_display_on_req)
    else $error("Display-off command did not clear the request.");

  AST_ON_REQ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n) s_on_cmd |=> o_display_on_req)
    else $error("Display-on command did not set the request.");

  AST_ONLY_ON_EXITS: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_display_on_req) |-> $past(is_cmd && cap_byte.data == GSD_CMD_DISPLAY_ON))
    else $error("Display left off state without display-on command.");

  AST_ONOFF_NO_GAMMA: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_on_cmd or s_off_cmd) |=> $stable(o_gamma_curve_select))
    else $error("Display on/off altered gamma selection.");

  AST_FRAME_SWITCH: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_display_on != $past(o_display_on)) |-> $past(frame_start_sync))
    else $error("Display output switched outside a frame boundary.");

  AST_DISPLAY_RESET: assert property (
    @(posedge i_clk_sys) !i_rst_n |=> !o_display_on && !o_display_on_req)
    else $error("Display not off after reset.");

  // A host byte reaches a register four clocks after its strobe rises: two synchroniser
  // stages, the capture flop (edge-detected against the prior strobe sample) and the register itself. The checks below
  // therefore watch the captured byte and its effect one clock later, never the raw pins.
  sequence s_gamma_cmd;
    is_cmd && cap_byte.data == GSD_CMD_GAMMA_SELECT;
  endsequence
  sequence s_gamma_param;
    state == GSD_ST_GAMMA_PARAM && is_param;
  endsequence
  sequence s_bad_param;
    state == GSD_ST_GAMMA_PARAM && is_param && !gamma_valid;
  endsequence
  sequence s_off_while_off;
    is_cmd && cap_byte.data == GSD_CMD_DISPLAY_OFF && !o_display_on_req && !o_display_on;
  endsequence
  sequence s_on_while_on;
    is_cmd && cap_byte.data == GSD_CMD_DISPLAY_ON && o_display_on_req && o_display_on;
  endsequence

  AST_STATE_ONEHOT: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $onehot(state))
    else $error("Command state is not one-hot.");

  AST_STATE_RESET: assert property (
    @(posedge i_clk_sys) !i_rst_n |=> state == GSD_ST_IDLE)
    else $error("Command state not idle after reset.");

  AST_GAMMA_ARMS: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_gamma_cmd |=> state == GSD_ST_GAMMA_PARAM)
    else $error("Gamma command did not arm the parameter wait.");

  AST_PARAM_DISARMS: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_gamma_param |=> state == GSD_ST_IDLE)
    else $error("Gamma parameter did not end the parameter wait.");

  // A bad parameter still ends the wait, so a stray second byte cannot
  // be taken as a late curve choice.
  AST_BAD_PARAM_KEEPS: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_bad_param |=> $stable(o_gamma_curve_select) && $stable(o_curve_onehot))
    else $error("Invalid gamma parameter changed the curve outputs.");

  AST_CURVE_MATCH: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_curve_onehot == o_gamma_curve_select[3:0])
    else $error("Curve bits disagree with the gamma selection.");

  AST_GAMMA_ONLY_BY_PARAM: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $changed(o_gamma_curve_select)
      |-> $past(state == GSD_ST_GAMMA_PARAM && is_param && gamma_valid))
    else $error("Gamma selection changed without a valid parameter.");

  AST_REQ_ONLY_BY_CMD: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $changed(o_display_on_req) |-> $past(is_cmd))
    else $error("Display request changed without a command.");

  AST_OFF_TWICE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_off_while_off |=> !o_display_on_req && !o_display_on)
    else $error("Repeated display-off command had an effect.");

  AST_ON_TWICE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_on_while_on |=> o_display_on_req && o_display_on)
    else $error("Repeated display-on command had an effect.");

  // If panel timing never marks a frame start, the output never follows the
  // request; that is the price of switching without a torn frame.
  AST_FRAME_TAKES_REQ: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      frame_start_sync |=> o_display_on == $past(o_display_on_req))
    else $error("Display output did not follow the request at a frame start.");

  AST_BLANK_WHILE_OFF: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (!o_display_on_req && !o_display_on) |=> !o_display_on)
    else $error("Frame memory reached the panel while display is off.");

  // The capture stage must refuse a strobe edge seen while a read is under way.
  AST_CAPTURE_READ_IDLE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      cap_valid |-> $past(sync_read_n))
    else $error("Byte captured while the read strobe was active.");

  AST_CAPTURE_ON_RISE: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      cap_valid |-> $past(sync_write_n) && !$past(sync_write_n, 2))
    else $error("Byte captured without a rising write strobe.");
endmodule // gsd_cmd_decoder

// file: verilog/gsd_pkg.sv
/*
  Shared constants and carrier types for the gamma-select and display on/off command block.
  Assumes an 8080-style host bus whose pins are sampled by the block's system clock.
*/
package gsd_pkg;
  localparam logic [7:0] GSD_CMD_GAMMA_SELECT = 8'h26;
  localparam logic [7:0] GSD_CMD_DISPLAY_OFF = 8'h28;
  localparam logic [7:0] GSD_CMD_DISPLAY_ON = 8'h29;
  localparam logic [7:0] GSD_GAMMA_CURVE_ONE = 8'h01;
  localparam logic [7:0] GSD_GAMMA_CURVE_TWO = 8'h02;
  localparam logic [7:0] GSD_GAMMA_CURVE_THREE = 8'h04;
  localparam logic [7:0] GSD_GAMMA_CURVE_FOUR = 8'h08;
  localparam logic [7:0] GSD_GAMMA_RESET = 8'h01;
  localparam int GSD_CURVE_ONE_BIT = 0;
  localparam int GSD_CURVE_TWO_BIT = 1;
  localparam int GSD_CURVE_THREE_BIT = 2;
  localparam int GSD_CURVE_FOUR_BIT = 3;
  localparam logic GSD_DISPLAY_ON_RESET = 1'b0;
  localparam int GSD_SYNC_STAGES = 2;

  typedef struct packed {
    logic cmd_data_select;
    logic [7:0] data;
  } gsd_byte_t;
endpackage

// file: verilog/gsd_sync.sv
/*
  Two-stage synchroniser for a bundle of level inputs.
  Assumes inputs are asynchronous to i_clk_sys; only the second stage is read outside.
*/
`timescale 1ns/1ps
module gsd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stage_one <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end
endmodule // gsd_sync
